// ---- src/cpp_power_path.sv ----
// Charger power-path control: input limit register, adapter detect,
// switch sequencing, battery switch mode, soft-start and cell latch.
// Assumes comparator levels are asynchronous and commands are synchronous.
`timescale 1ns/10ps
`default_nettype none
module cpp_power_path #(
    parameter int unsigned GATE_CHECK_CYCLES = cpp_pkg::GATE_CHECK_CYC,
    parameter int unsigned LOCK_CYCLES = cpp_pkg::LOCK_CYC
) (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Host command port
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_cmd_code,
    input wire logic [15:0] i_cmd_wdata,
    output logic [15:0] o_input_limit_word,
    // Option and setting levels
    input wire logic i_linear_mode_en,
    input wire logic i_input_priority_enable,
    input wire logic i_charge_en,
    input wire logic i_learn_en,
    input wire logic [6:0] i_charge_current_field,
    // Comparator levels
    input wire logic i_vcc_ovp,
    input wire logic i_vcc_below_recover,
    input wire logic i_adapter_detect_in,
    input wire logic i_vcc_above_uvlo,
    input wire logic i_vcc_above_battery_sense_node,
    input wire logic i_gate_drive_ok,
    input wire logic i_bat_above_min_sys,
    input wire logic i_discharge_over_thr,
    input wire logic i_input_over_limit,
    input wire logic i_cell_pin,
    // Open-drain adapter-ok
    output logic o_adapter_ok_out_o,
    output logic o_adapter_ok_out_oe,
    // Switch control
    output logic o_adapter_switch_on,
    output logic o_adapter_switch_drive_to_src,
    output logic o_battery_switch_on,
    output logic o_battery_switch_linear,
    // Converter and charge
    output logic o_converter_en,
    output logic o_charge_active,
    output logic o_charge_reduce,
    output logic o_softstart_active,
    output logic [6:0] o_current_target,
    // Cell configuration
    output logic o_cell_three,
    output logic o_cell_locked
);
    // ==========================================================
    // Types and state
    typedef enum logic [1:0] {
        SW_OFF,
        SW_CHECK,
        SW_ON,
        SW_FAULT
    } cpp_sw_type;

    typedef struct packed {
        logic [6:0] limit_field;
        logic ovp_hold;
        cpp_sw_type sw;
        logic [17:0] gate_cnt;
        logic conv_en;
        logic learn_d;
        logic skip_ss;
        logic ss_active;
        logic [7:0] step_cnt;
        logic [6:0] ss_target;
        logic ever_switched;
        logic [19:0] lock_cnt;
        logic cell_locked;
        logic cell_three;
        logic adapter_ok;
        logic bat_on;
        logic bat_linear;
        logic charge_active;
        logic charge_reduce;
        logic [6:0] target;
    } cpp_state_type;

    cpp_state_type st_r;
    cpp_state_type st_nxt;

    localparam logic [17:0] GATE_LAST = 18'(GATE_CHECK_CYCLES - 1);
    localparam logic [19:0] LOCK_LAST = 20'(LOCK_CYCLES - 1);
    localparam logic [7:0] STEP_LAST = 8'(cpp_pkg::STEP_CYC - 1);
    localparam logic [15:0] LIMIT_RESET_W = cpp_pkg::LIMIT_RESET;

    function automatic logic [6:0] cpp_min7(input logic [6:0] a, input logic [6:0] b);
        cpp_min7 = (a < b) ? a : b;
    endfunction : cpp_min7

    // ==========================================================
    // Comparator synchronisation
    cpp_sync_if sif ();
    logic [cpp_pkg::NUM_CMP-1:0] cmp;

    assign sif.raw[cpp_pkg::CMP_OVP] = i_vcc_ovp;
    assign sif.raw[cpp_pkg::CMP_OV_RECOVER] = i_vcc_below_recover;
    assign sif.raw[cpp_pkg::CMP_ADAPTER_DETECT_IN] = i_adapter_detect_in;
    assign sif.raw[cpp_pkg::CMP_UVLO_OK] = i_vcc_above_uvlo;
    assign sif.raw[cpp_pkg::CMP_NOT_SLEEP] = i_vcc_above_battery_sense_node;
    assign sif.raw[cpp_pkg::CMP_GATE_OK] = i_gate_drive_ok;
    assign sif.raw[cpp_pkg::CMP_BAT_ABOVE_MIN] = i_bat_above_min_sys;
    assign sif.raw[cpp_pkg::CMP_DISCHG] = i_discharge_over_thr;
    assign sif.raw[cpp_pkg::CMP_IN_OVER] = i_input_over_limit;
    assign sif.raw[cpp_pkg::CMP_CELL] = i_cell_pin;

    cpp_sync u_sync (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .sif(sif.sync_side)
    );

    assign cmp = sif.stable;

    // ==========================================================
    // Next-state logic
    logic [6:0] wr_field;
    logic wr_ok;
    logic ovp_now;
    logic adapter_detect_in;
    logic adapter_ok_nxt;
    logic path_on_nxt;
    logic conv_nxt;
    logic [6:0] chg_limit;

    always_comb begin
        st_nxt = st_r;
        wr_field = i_cmd_wdata[cpp_pkg::FIELD_LSB +: cpp_pkg::FIELD_W];
        wr_ok = (wr_field >= cpp_pkg::LIMIT_MIN_FIELD)
            && (wr_field <= cpp_pkg::LIMIT_MAX_FIELD);
        ovp_now = cmp[cpp_pkg::CMP_OVP];
        adapter_detect_in = cmp[cpp_pkg::CMP_ADAPTER_DETECT_IN];

        // Input limit register
        if (i_cmd_wr && (i_cmd_code == cpp_pkg::CMD_INPUT_LIMIT) && wr_ok) begin
            st_nxt.limit_field = wr_field;
        end

        // Over-voltage hold: set wins over recovery
        if (ovp_now) begin
            st_nxt.ovp_hold = 1'b1;
        end else if (cmp[cpp_pkg::CMP_OV_RECOVER] && adapter_detect_in) begin
            st_nxt.ovp_hold = 1'b0;
        end

        adapter_ok_nxt = cmp[cpp_pkg::CMP_UVLO_OK] && !ovp_now && !st_nxt.ovp_hold
            && adapter_detect_in && cmp[cpp_pkg::CMP_NOT_SLEEP];
        st_nxt.adapter_ok = adapter_ok_nxt;

        // Adapter and reverse-block switch sequencing
        unique case (st_r.sw)
            SW_OFF: begin
                st_nxt.gate_cnt = '0;
                if (adapter_ok_nxt) begin
                    st_nxt.sw = SW_CHECK;
                end
            end
            SW_CHECK: begin
                st_nxt.gate_cnt = st_r.gate_cnt + 18'h00001;
                if (!adapter_ok_nxt) begin
                    st_nxt.sw = SW_OFF;
                end else if (cmp[cpp_pkg::CMP_GATE_OK]) begin
                    st_nxt.sw = SW_ON;
                end else if (st_r.gate_cnt == GATE_LAST) begin
                    st_nxt.sw = SW_FAULT;
                end
            end
            SW_ON: begin
                if (!adapter_ok_nxt) begin
                    st_nxt.sw = SW_OFF;
                end
            end
            SW_FAULT: begin
                // Retry only after the adapter is removed
                if (!adapter_detect_in) begin
                    st_nxt.sw = SW_OFF;
                end
            end
        endcase
        path_on_nxt = (st_nxt.sw == SW_CHECK) || (st_nxt.sw == SW_ON);

        // Converter runs only behind a fully-on adapter switch
        conv_nxt = (st_nxt.sw == SW_ON) && !i_learn_en && !st_nxt.ovp_hold;
        st_nxt.conv_en = conv_nxt;
        st_nxt.learn_d = i_learn_en;
        chg_limit = i_charge_current_field;

        // Soft-start bypass is armed by leaving calibration mode
        if (conv_nxt && !st_r.conv_en) begin
            st_nxt.skip_ss = 1'b0;
        end else if (st_r.learn_d && !i_learn_en) begin
            st_nxt.skip_ss = 1'b1;
        end

        if (!conv_nxt) begin
            st_nxt.ss_active = 1'b0;
            st_nxt.ss_target = '0;
            st_nxt.step_cnt = '0;
        end else if (!st_r.conv_en) begin
            st_nxt.step_cnt = '0;
            if (st_r.skip_ss || (st_r.learn_d && !i_learn_en)) begin
                st_nxt.ss_active = 1'b0;
                st_nxt.ss_target = chg_limit;
            end else begin
                st_nxt.ss_active = 1'b1;
                st_nxt.ss_target = cpp_min7(cpp_pkg::SS_START_FIELD, chg_limit);
            end
        end else if (st_r.ss_active) begin
            if (st_r.ss_target >= chg_limit) begin
                st_nxt.ss_active = 1'b0;
                st_nxt.ss_target = chg_limit;
            end else if (st_r.step_cnt == STEP_LAST) begin
                st_nxt.step_cnt = '0;
                st_nxt.ss_target = st_r.ss_target + 7'h01;
            end else begin
                st_nxt.step_cnt = st_r.step_cnt + 8'h01;
            end
        end else begin
            st_nxt.ss_target = chg_limit;
        end

        // Charge gating and input priority
        st_nxt.charge_active = i_charge_en && conv_nxt && !st_nxt.ovp_hold;
        st_nxt.charge_reduce = i_input_priority_enable
            && cmp[cpp_pkg::CMP_IN_OVER] && st_nxt.charge_active;

        // Battery switch: on without adapter, in over-voltage, on discharge, while charging and in learn mode
        st_nxt.bat_on = !path_on_nxt
            || st_nxt.ovp_hold
            || cmp[cpp_pkg::CMP_DISCHG]
            || st_nxt.charge_active
            || i_learn_en;
        st_nxt.bat_linear = st_nxt.bat_on && i_linear_mode_en
            && !cmp[cpp_pkg::CMP_BAT_ABOVE_MIN];

        // Precharge clamp applies while the battery switch is linear
        if (!st_nxt.charge_active) begin
            st_nxt.target = '0;
        end else if (st_nxt.bat_linear) begin
            st_nxt.target = cpp_min7(st_nxt.ss_target, cpp_pkg::PRECHG_MAX_FIELD);
        end else begin
            st_nxt.target = st_nxt.ss_target;
        end

        // Cell-count latch
        if (conv_nxt) begin
            st_nxt.ever_switched = 1'b1;
        end
        if (!st_r.cell_locked) begin
            st_nxt.cell_three = cmp[cpp_pkg::CMP_CELL];
            if (st_r.ever_switched) begin
                if (st_r.lock_cnt == LOCK_LAST) begin
                    st_nxt.cell_locked = 1'b1;
                end else begin
                    st_nxt.lock_cnt = st_r.lock_cnt + 20'h00001;
                end
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            st_r <= '0;
            st_r.limit_field <= LIMIT_RESET_W[cpp_pkg::FIELD_LSB +: cpp_pkg::FIELD_W];
            st_r.sw <= SW_OFF;
            st_r.bat_on <= 1'b1;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign o_input_limit_word = {3'h0, st_r.limit_field, 6'h00};
    // Open drain: only ever pulls low, pull-up gives the high level
    assign o_adapter_ok_out_o = 1'b0;
    assign o_adapter_ok_out_oe = !st_r.adapter_ok;
    assign o_adapter_switch_on = (st_r.sw == SW_CHECK) || (st_r.sw == SW_ON);
    assign o_adapter_switch_drive_to_src = !o_adapter_switch_on;
    assign o_battery_switch_on = st_r.bat_on;
    assign o_battery_switch_linear = st_r.bat_linear;
    assign o_converter_en = st_r.conv_en;
    assign o_charge_active = st_r.charge_active;
    assign o_charge_reduce = st_r.charge_reduce;
    assign o_softstart_active = st_r.ss_active;
    assign o_current_target = st_r.target;
    assign o_cell_three = st_r.cell_three;
    assign o_cell_locked = st_r.cell_locked;
endmodule : cpp_power_path
`default_nettype wire

// ---- src/cpp_pkg.sv ----
// Constants for the charger power-path control block.
// Assumes a 10 MHz control clock and comparator levels from the analog side.
package cpp_pkg;
    // ==========================================================
    // Command and input-limit register
    localparam logic [7:0] CMD_INPUT_LIMIT = 8'h3F;
    localparam int FIELD_LSB = 6;
    localparam int FIELD_W = 7;
    localparam logic [15:0] LIMIT_RESET = 16'h0C80;
    localparam logic [6:0] LIMIT_MIN_FIELD = 7'h02;
    localparam logic [6:0] LIMIT_MAX_FIELD = 7'h7E;
    // ==========================================================
    // Current targets in 64 mA units
    localparam logic [6:0] SS_START_FIELD = 7'h02;
    localparam logic [6:0] PRECHG_MAX_FIELD = 7'h05;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int GATE_CHECK_MS = 20;
    localparam int STEP_US = 24;
    localparam int LOCK_MS = 100;
    localparam int GATE_CHECK_CYC = GATE_CHECK_MS * (CLK_HZ / 1000);
    localparam int STEP_CYC = STEP_US * (CLK_HZ / 1_000_000);
    localparam int LOCK_CYC = LOCK_MS * (CLK_HZ / 1000);
    // ==========================================================
    // Comparator vector positions
    localparam int NUM_CMP = 10;
    localparam int CMP_OVP = 0;
    localparam int CMP_OV_RECOVER = 1;
    localparam int CMP_ADAPTER_DETECT_IN = 2;
    localparam int CMP_UVLO_OK = 3;
    localparam int CMP_NOT_SLEEP = 4;
    localparam int CMP_GATE_OK = 5;
    localparam int CMP_BAT_ABOVE_MIN = 6;
    localparam int CMP_DISCHG = 7;
    localparam int CMP_IN_OVER = 8;
    localparam int CMP_CELL = 9;
endpackage : cpp_pkg

// ---- src/cpp_sync_if.sv ----
// Carries raw comparator levels in and their synchronised copies out.
// Assumes one clock domain on the synchronised side.
`timescale 1ns/10ps
`default_nettype none
interface cpp_sync_if;
    logic [cpp_pkg::NUM_CMP-1:0] raw;
    logic [cpp_pkg::NUM_CMP-1:0] stable;
    modport sync_side (input raw, output stable);
    modport user_side (output raw, input stable);
endinterface : cpp_sync_if
`default_nettype wire

// ---- src/cpp_sync.sv ----
// Three-stage synchroniser for asynchronous comparator levels.
// A change is accepted once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module cpp_sync (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Levels
    cpp_sync_if.sync_side sif
);
    typedef struct packed {
        logic [cpp_pkg::NUM_CMP-1:0] s1;
        logic [cpp_pkg::NUM_CMP-1:0] s2;
        logic [cpp_pkg::NUM_CMP-1:0] s3;
        logic [cpp_pkg::NUM_CMP-1:0] stable;
    } cpp_sync_type;

    cpp_sync_type st_r;
    cpp_sync_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = sif.raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < cpp_pkg::NUM_CMP; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.stable[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            st_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign sif.stable = st_r.stable;
endmodule : cpp_sync
`default_nettype wire

// ---- verification/cpp_host_model.sv ----
// Host model: drives word writes into the command port.
// Assumes the block samples the strobe on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module cpp_host_model (
    // Clock
    input wire logic i_mclk,
    // Command port
    output logic o_cmd_wr,
    output logic [7:0] o_cmd_code,
    output logic [15:0] o_cmd_wdata
);
    // ==========================================
    // Word write
    initial begin
        o_cmd_wr = 1'b0;
        o_cmd_code = 8'h00;
        o_cmd_wdata = 16'h0000;
    end
    // One-cycle strobe, code and word whole
    task automatic write_word(input logic [7:0] code, input logic [15:0] data);
        @(negedge i_mclk);
        o_cmd_wr = 1'b1;
        o_cmd_code = code;
        o_cmd_wdata = data;
        @(negedge i_mclk);
        o_cmd_wr = 1'b0;
        // Idle bus shows inverted data, not a stale copy
        o_cmd_code = ~code;
        o_cmd_wdata = ~data;
    endtask : write_word
endmodule : cpp_host_model
`default_nettype wire

// ---- verification/cpp_power_path_asserts.sv ----
// Port checker for the power-path block.
// Assumes i_ce held high; bound at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module cpp_power_path_asserts (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Watched ports
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_cmd_code,
    input wire logic [15:0] i_cmd_wdata,
    input wire logic [15:0] o_input_limit_word,
    input wire logic i_vcc_ovp,
    input wire logic i_adapter_detect_in,
    input wire logic i_linear_mode_en,
    input wire logic o_adapter_ok_out_oe,
    input wire logic o_adapter_switch_on,
    input wire logic o_adapter_switch_drive_to_src,
    input wire logic o_battery_switch_on,
    input wire logic o_battery_switch_linear,
    input wire logic o_converter_en,
    input wire logic o_charge_active,
    input wire logic o_charge_reduce,
    input wire logic o_cell_three,
    input wire logic o_cell_locked
);
    // ==========================================
    // Properties
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    logic wr_ok;
    assign wr_ok = i_cmd_code == 8'h3F && i_cmd_wdata[12:6] >= 7'h02 && i_cmd_wdata[12:6] <= 7'h7E;
    a_limit_reset: assert property (disable iff (1'b0) !i_rst_b |=> o_input_limit_word == 16'h0C80)
        else $error("limit word not at reset value");
    a_write_taken: assert property (i_cmd_wr && wr_ok |=>
        o_input_limit_word == {3'h0, $past(i_cmd_wdata[12:6]), 6'h00})
        else $error("accepted write not stored");
    a_write_dropped: assert property (i_cmd_wr && !wr_ok |=> $stable(o_input_limit_word))
        else $error("refused write changed limit");
    a_ovp_cuts: assert property (i_vcc_ovp [*6] |=> o_adapter_ok_out_oe && !o_adapter_switch_on
        && !o_charge_active && o_battery_switch_on)
        else $error("over-voltage response missing");
    a_no_adapter: assert property (!i_adapter_detect_in [*6] |=> o_adapter_ok_out_oe
        && o_adapter_switch_drive_to_src && o_battery_switch_on)
        else $error("no-adapter state wrong");
    a_drive_pair: assert property ((o_adapter_switch_drive_to_src != o_adapter_switch_on)
        && (o_adapter_switch_on || o_battery_switch_on))
        else $error("drive tie wrong or no supply path");
    a_conv_after_sw: assert property (o_converter_en |-> o_adapter_switch_on)
        else $error("converter on without adapter switch");
    a_linear_off: assert property (!i_linear_mode_en [*6] |=> !o_battery_switch_linear)
        else $error("linear mode with option cleared");
    a_reduce_gated: assert property (o_charge_reduce |-> o_charge_active)
        else $error("reduce without charging");
    a_cell_frozen: assert property (o_cell_locked && $past(o_cell_locked) |-> $stable(o_cell_three))
        else $error("locked cell setting moved");
endmodule : cpp_power_path_asserts
bind cpp_power_path cpp_power_path_asserts u_chk (.i_mclk, .i_rst_b, .i_cmd_wr, .i_cmd_code, .i_cmd_wdata,
    .o_input_limit_word, .i_vcc_ovp, .i_adapter_detect_in, .i_linear_mode_en, .o_adapter_ok_out_oe,
    .o_adapter_switch_on, .o_adapter_switch_drive_to_src, .o_battery_switch_on, .o_battery_switch_linear,
    .o_converter_en, .o_charge_active, .o_charge_reduce, .o_cell_three, .o_cell_locked);
`default_nettype wire

// ---- verification/charger_power_path_control_bench.sv ----
// Bench for the power-path block: host writes and comparator stimulus.
// Assumes short gate-check and lock counts; i_ce held high.
`timescale 1ns/10ps
`default_nettype none
module charger_power_path_control_bench;
    // ==========================================
    // Signals and instances
    localparam int GC = 50;
    localparam int LK = 100;
    logic i_mclk, i_rst_b, i_ce, i_cmd_wr, i_linear_mode_en, i_input_priority_enable, i_charge_en, i_learn_en;
    logic [7:0] i_cmd_code;
    logic [15:0] i_cmd_wdata, o_input_limit_word, exp_word;
    logic [6:0] i_charge_current_field, o_current_target;
    logic i_vcc_ovp, i_vcc_below_recover, i_adapter_detect_in, i_vcc_above_uvlo, i_vcc_above_battery_sense_node;
    logic i_gate_drive_ok, i_bat_above_min_sys, i_discharge_over_thr, i_input_over_limit, i_cell_pin;
    logic o_adapter_ok_out_o, o_adapter_ok_out_oe, o_adapter_switch_on, o_adapter_switch_drive_to_src;
    logic o_battery_switch_on, o_battery_switch_linear, o_converter_en, o_charge_active;
    logic o_charge_reduce, o_softstart_active, o_cell_three, o_cell_locked;
    logic [23:0] wr_tab [6] = '{24'h3F1900, 24'h3F0040, 24'h3F1FC0, 24'h3FE0BF, 24'h3E0400, 24'h3F1F80};
    int mismatches, checks, n;
    cpp_host_model host (.i_mclk, .o_cmd_wr(i_cmd_wr), .o_cmd_code(i_cmd_code), .o_cmd_wdata(i_cmd_wdata));
    cpp_power_path #(.GATE_CHECK_CYCLES(GC), .LOCK_CYCLES(LK)) dut (.*);
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    // ==========================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge i_mclk);
    endtask : tick
    function automatic logic pick(input int s);
        case (s)
            0: return o_adapter_switch_on;
            1: return o_converter_en;
            default: return o_current_target == i_charge_current_field;
        endcase
    endfunction : pick
    // Bounded wait; running out ends the run
    task automatic wait_for(input int s, input int lim);
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(negedge i_mclk);
            n++;
        end
        if (n >= lim) begin
            chk(16'h0000, 16'h0001);
            wrap_up();
        end
    endtask : wait_for
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // ==========================================
    // Sequence
    initial begin
        {i_rst_b, i_input_priority_enable, i_charge_en, i_learn_en, i_vcc_ovp, i_adapter_detect_in} = 6'h00;
        {i_discharge_over_thr, i_input_over_limit, i_cell_pin} = 3'h0;
        {i_ce, i_linear_mode_en, i_vcc_below_recover, i_vcc_above_uvlo} = 4'hF;
        {i_vcc_above_battery_sense_node, i_gate_drive_ok, i_bat_above_min_sys} = 3'h7;
        i_charge_current_field = 7'h0A;
        exp_word = 16'h0C80;
        mismatches = 0;
        checks = 0;
        tick(6);
        i_rst_b = 1'b1;
        tick(6);
        chk(o_input_limit_word, 16'h0C80);
        chk(o_cell_three, 1'b0);
        chk(o_adapter_ok_out_o, 1'b0);
        chk({o_adapter_ok_out_oe, o_adapter_switch_drive_to_src, o_battery_switch_on}, 3'h7);
        $display("test reset done");
        foreach (wr_tab[k]) begin
            host.write_word(wr_tab[k][23:16], wr_tab[k][15:0]);
            @(negedge i_mclk);
            if (wr_tab[k][23:16] == 8'h3F && wr_tab[k][12:6] inside {[7'h02:7'h7E]}) begin
                exp_word = {3'h0, wr_tab[k][12:6], 6'h00};
            end
            chk(o_input_limit_word, exp_word);
        end
        $display("test limit writes done");
        // Battery present, so the host may enable charging
        i_charge_en = 1'b1;
        i_cell_pin = 1'b1;
        i_adapter_detect_in = 1'b1;
        wait_for(0, 20);
        wait_for(1, 20);
        chk(o_adapter_ok_out_oe, 1'b0);
        chk({o_softstart_active, o_current_target}, 8'h82);
        wait_for(2, 2500);
        chk(n inside {[1910:1930]}, 1'b1);
        chk({o_cell_locked, o_cell_three}, 2'h3);
        i_cell_pin = 1'b0;
        tick(6);
        chk(o_cell_three, 1'b1);
        $display("test adapter start done");
        i_learn_en = 1'b1;
        tick(6);
        chk({o_converter_en, o_battery_switch_on}, 2'h1);
        i_learn_en = 1'b0;
        wait_for(1, 20);
        chk({o_softstart_active, o_current_target}, 8'h0A);
        i_input_priority_enable = 1'b1;
        i_input_over_limit = 1'b1;
        tick(6);
        chk(o_charge_reduce, 1'b1);
        i_input_priority_enable = 1'b0;
        tick(6);
        chk(o_charge_reduce, 1'b0);
        i_charge_en = 1'b0;
        i_discharge_over_thr = 1'b1;
        tick(6);
        chk(o_battery_switch_on, 1'b1);
        i_discharge_over_thr = 1'b0;
        tick(6);
        chk(o_battery_switch_on, 1'b0);
        i_charge_en = 1'b1;
        i_bat_above_min_sys = 1'b0;
        tick(6);
        chk({o_battery_switch_linear, o_current_target}, 8'h85);
        i_linear_mode_en = 1'b0;
        tick(6);
        chk(o_battery_switch_linear, 1'b0);
        i_linear_mode_en = 1'b1;
        i_bat_above_min_sys = 1'b1;
        tick(6);
        chk(o_battery_switch_linear, 1'b0);
        $display("test charge modes done");
        i_vcc_ovp = 1'b1;
        i_vcc_below_recover = 1'b0;
        tick(6);
        chk({o_adapter_ok_out_oe, o_adapter_switch_on, o_battery_switch_on, o_charge_active}, 4'hA);
        i_vcc_ovp = 1'b0;
        tick(6);
        chk(o_adapter_switch_on, 1'b0);
        i_vcc_below_recover = 1'b1;
        wait_for(0, 20);
        tick(2);
        chk(o_adapter_ok_out_oe, 1'b0);
        $display("test over-voltage done");
        i_adapter_detect_in = 1'b0;
        i_gate_drive_ok = 1'b0;
        tick(6);
        i_adapter_detect_in = 1'b1;
        wait_for(0, 20);
        tick(GC - 5);
        chk(o_adapter_switch_on, 1'b1);
        tick(15);
        chk({o_adapter_switch_on, o_adapter_switch_drive_to_src}, 2'h1);
        $display("test gate fault done");
        wrap_up();
    end
endmodule : charger_power_path_control_bench
`default_nettype wire
